// ===== rtl/cirs_sequencer.sv
// Core interrupt latching, priority resolution and pipeline redirect
`timescale 1ns/10ps
`include "cirs_cfg.svh"
// Operation
// - Vector branch takes four core cycles from on-chip memory.
// - Single-cycle case: latch and recognise cycle two, push and vector cycle three.
// - One instruction completes; the four younger ones become no-operations.
// - External request inputs see five extra cycles of response latency.
// - Delayed branch plus two slots complete; processing deferred until cycle five.
// - Program-memory conflict stalls; cycle five pushes next address and vectors.
// - With nesting, higher interrupt waits until first lower handler instruction executes.
// - Priorities are fixed in hardware and cannot be reordered.
// - Each primary latch bit has a mask bit; extended register holds both.
// - Priority runs from bit 0 highest to 41 lowest.
// - The same fixed order decides which interrupts may nest.
// - Nineteen programmable slots receive routed peripheral requests.
// - Recognising an interrupt sets its latch bit as pending.
// - Software reads and writes latches, except reset and emulator bits.
// - In-service interrupt's latch bit is cleared every cycle.
// - Return-from-interrupt stops the per-cycle clearing.
// - Jump-with-clear ends in-service state so the interrupt can latch again.
// - Respond only when running, unmasked, globally enabled, nothing higher pending.
// - One cycle synchronisation, one cycle latch and recognise, then vector.
// - On taking: vector out, return pushed, status pushed for external/timer, latch reset.
// - Vector table entries are four instruction locations apart.
module cirs_sequencer #(
	parameter int ADDR_W = 24,
	parameter logic [23:0] VEC_BASE = 24'h000000
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Interrupt sources
	input wire logic [41:0] core_req,
	input wire logic [2:0] external_request_inputs,
	input wire logic [18:0] periph_slot_req,
	// Control bits
	input wire logic global_enable,
	input wire logic nest_enable,
	input wire logic core_running,
	// Software access to latches and masks
	input wire logic primary_latch_we,
	input wire logic [31:0] primary_latch_wdata,
	input wire logic primary_mask_we,
	input wire logic [31:0] primary_mask_wdata,
	input wire logic extended_we,
	input wire logic [19:0] extended_wdata,
	// Pipeline status
	input wire logic delayed_branch,
	input wire logic pm_conflict,
	input wire logic rti_exec,
	input wire logic jump_clear_interrupt,
	input wire logic [23:0] return_addr,
	// Register views
	output logic [31:0] primary_latch_reg,
	output logic [31:0] primary_mask_reg,
	output logic [19:0] extended_latch_mask_reg,
	// Pipeline redirect
	output logic vector_fetch,
	output logic [23:0] vector_addr,
	output logic pc_push,
	output logic [23:0] pc_push_data,
	output logic status_push,
	output logic squash,
	output logic [41:0] in_service
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Lowest set index wins: fixed order, no reorder register exists
	function automatic logic [6:0] cirs_first(input cirs_pkg::cirs_vec_t v);
		logic [6:0] r;
		r = 7'h00;
		for (int i = `CIRS_NUM_IRQ - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 6'(i)};
			end
		end
		return r;
	endfunction : cirs_first

	function automatic cirs_pkg::cirs_vec_t cirs_onehot(input logic [5:0] idx);
		return cirs_pkg::cirs_vec_t'(42'h1) << idx;
	endfunction : cirs_onehot

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	cirs_pkg::cirs_vec_t latch_reg, latch_next;
	cirs_pkg::cirs_vec_t mask_reg, mask_next;
	cirs_pkg::cirs_vec_t active_reg, active_next;
	cirs_pkg::cirs_vec_t sync_reg;
	logic [2:0] ext_dly_reg [0:`CIRS_EXT_LATENCY-1];
	cirs_pkg::cirs_state_t state_reg, state_next;
	logic [2:0] blk_cnt_reg, blk_cnt_next;
	logic [1:0] defer_cnt_reg;
	logic defer_pm_reg;
	logic [2:0] sq_cnt_reg;

	// ----------------------------------------------------------------
	// Request gathering
	// ----------------------------------------------------------------
	// External inputs pass a five-stage delay before synchronisation
	cirs_pkg::cirs_vec_t raw_req;
	cirs_pkg::cirs_vec_t ext_req;
	cirs_pkg::cirs_vec_t slot_req;
	assign ext_req = cirs_pkg::cirs_vec_t'(ext_dly_reg[`CIRS_EXT_LATENCY-1]) << `CIRS_BIT_EXT_LSB;
	assign slot_req = cirs_pkg::cirs_vec_t'(periph_slot_req) << `CIRS_PSLOT_LSB;
	// Requests are levels; the source drops them on acknowledge
	assign raw_req = (core_req & ~cirs_pkg::cirs_vec_t'(42'h700) ) | ext_req | slot_req;

	// ----------------------------------------------------------------
	// Selection and take decision
	// ----------------------------------------------------------------
	cirs_pkg::cirs_vec_t pend_unmasked;
	logic [6:0] sel;
	logic [6:0] act;
	logic nest_ok;
	logic deferred;
	logic take;
	logic [5:0] sel_idx;
	logic ext_or_timer;
	assign pend_unmasked = latch_reg & mask_reg;
	assign sel = cirs_first(pend_unmasked);
	assign act = cirs_first(active_reg);
	assign sel_idx = sel[5:0];
	// Nesting admits only a strictly higher priority than the one in service
	assign nest_ok = !act[6] || (nest_enable && (sel_idx < act[5:0]));
	// Branch slots or a memory conflict hold processing; latch stays pending
	assign deferred = (defer_cnt_reg != 2'h0) || delayed_branch || pm_conflict;
	assign take = sel[6] && global_enable && core_running && nest_ok && !deferred
		&& (state_reg == cirs_pkg::CIRS_RUN) && (blk_cnt_reg == 3'h0);
	assign ext_or_timer = (sel_idx == 6'(`CIRS_BIT_TIMER))
		|| ((sel_idx >= 6'(`CIRS_BIT_EXT_LSB))
		&& (sel_idx < 6'(`CIRS_BIT_EXT_LSB + `CIRS_NUM_EXT)));

	// ----------------------------------------------------------------
	// Latch and mask next values
	// ----------------------------------------------------------------
	cirs_pkg::cirs_vec_t sw_latch;
	cirs_pkg::cirs_vec_t sw_protect;
	cirs_pkg::cirs_vec_t take_clr;
	assign sw_protect = cirs_onehot(6'(`CIRS_BIT_RESET)) | cirs_onehot(6'(`CIRS_BIT_EMU));
	// Software writes leave reset and emulator bits untouched
	always_comb begin
		sw_latch = latch_reg;
		if (primary_latch_we) begin
			sw_latch[31:0] = primary_latch_wdata;
		end
		if (extended_we) begin
			sw_latch[41:32] = extended_wdata[9:0];
		end
		sw_latch = (sw_latch & ~sw_protect) | (latch_reg & sw_protect);
	end
	assign take_clr = take ? cirs_onehot(sel_idx) : '0;
	// New requests win over a software clear; in-service bits are held clear
	assign latch_next = ((sw_latch | sync_reg) & ~active_next) & ~take_clr;

	always_comb begin
		mask_next = mask_reg;
		if (primary_mask_we) begin
			mask_next[31:0] = primary_mask_wdata;
		end
		if (extended_we) begin
			mask_next[41:32] = extended_wdata[19:10];
		end
		mask_next = mask_next | `CIRS_MASK_RESET; // Reset and emulator are never masked
	end

	// ----------------------------------------------------------------
	// In-service tracking
	// ----------------------------------------------------------------
	// Return or jump-with-clear retires the most recent (highest) service
	always_comb begin
		active_next = active_reg;
		if ((rti_exec || jump_clear_interrupt) && act[6]) begin
			active_next = active_reg & ~cirs_onehot(act[5:0]);
		end
		if (take) begin
			active_next = active_next | cirs_onehot(sel_idx);
		end
	end

	// ----------------------------------------------------------------
	// Redirect sequence
	// ----------------------------------------------------------------
	// Vector fetch spans four cycles, then the first handler instruction
	always_comb begin
		state_next = state_reg;
		blk_cnt_next = blk_cnt_reg;
		case (state_reg)
			cirs_pkg::CIRS_RUN: begin
				if (take) begin
					state_next = cirs_pkg::CIRS_VECTOR;
					blk_cnt_next = 3'(`CIRS_BLOCK_CYCLES - 1);
				end
			end
			cirs_pkg::CIRS_VECTOR: begin
				blk_cnt_next = blk_cnt_reg - 3'h1;
				if (blk_cnt_reg == 3'h1) begin
					state_next = cirs_pkg::CIRS_FIRST;
				end
			end
			cirs_pkg::CIRS_FIRST: begin
				blk_cnt_next = 3'h0;
				state_next = cirs_pkg::CIRS_RUN;
			end
			default: begin
				state_next = cirs_pkg::CIRS_RUN;
				blk_cnt_next = 3'h0;
			end
		endcase
	end

	logic [23:0] vec_next;
	logic [23:0] push_next;
	assign vec_next = VEC_BASE + 24'(sel_idx) * 24'(`CIRS_VEC_SPACING);
	// After a memory conflict the instruction after n is the return point
	assign push_next = defer_pm_reg ? return_addr + 24'h1 : return_addr;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Synchronise cycle one, latch cycle two, act in cycle three
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			sync_reg <= '0;
			latch_reg <= '0;
			mask_reg <= `CIRS_MASK_RESET;
			active_reg <= '0;
		end else begin
			sync_reg <= raw_req;
			latch_reg <= latch_next;
			mask_reg <= mask_next;
			active_reg <= active_next;
		end
	end

	// Delay line for the external request inputs
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			for (int i = 0; i < `CIRS_EXT_LATENCY; i++) begin
				ext_dly_reg[i] <= 3'h0;
			end
		end else begin
			ext_dly_reg[0] <= external_request_inputs;
			for (int i = 1; i < `CIRS_EXT_LATENCY; i++) begin
				ext_dly_reg[i] <= ext_dly_reg[i-1];
			end
		end
	end

	// Deferral window: two cycles after the branch or stall is seen
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			defer_cnt_reg <= 2'h0;
			defer_pm_reg <= 1'b0;
		end else if (delayed_branch || pm_conflict) begin
			defer_cnt_reg <= 2'(`CIRS_DEFER_CYCLES);
			defer_pm_reg <= pm_conflict;
		end else if (defer_cnt_reg != 2'h0) begin
			defer_cnt_reg <= defer_cnt_reg - 2'h1;
		end else if (take) begin
			defer_pm_reg <= 1'b0;
		end
	end

	// Sequencer state
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state_reg <= cirs_pkg::CIRS_RUN;
			blk_cnt_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			blk_cnt_reg <= blk_cnt_next;
		end
	end

	// Squash the four younger instructions behind the one that completes
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			sq_cnt_reg <= 3'h0;
			squash <= 1'b0;
		end else if (take) begin
			sq_cnt_reg <= 3'(`CIRS_SQUASH_COUNT - 1);
			squash <= 1'b1;
		end else begin
			sq_cnt_reg <= (sq_cnt_reg != 3'h0) ? sq_cnt_reg - 3'h1 : 3'h0;
			squash <= (sq_cnt_reg != 3'h0);
		end
	end

	// Redirect outputs, one-cycle pulses with held addresses
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			vector_fetch <= 1'b0;
			vector_addr <= 24'h000000;
			pc_push <= 1'b0;
			pc_push_data <= 24'h000000;
			status_push <= 1'b0;
		end else begin
			vector_fetch <= take;
			pc_push <= take;
			status_push <= take && ext_or_timer;
			if (take) begin
				vector_addr <= vec_next;
				pc_push_data <= push_next;
			end
		end
	end

	// Software-visible views
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			primary_latch_reg <= 32'h00000000;
			primary_mask_reg <= 32'(`CIRS_MASK_RESET);
			extended_latch_mask_reg <= 20'h00000;
			in_service <= '0;
		end else begin
			primary_latch_reg <= latch_next[31:0];
			primary_mask_reg <= mask_next[31:0];
			extended_latch_mask_reg <= {mask_next[41:32], latch_next[41:32]};
			in_service <= active_next;
		end
	end

endmodule : cirs_sequencer

// ===== rtl/cirs_cfg.svh
// Offsets, field positions, reset values and timing counts for the interrupt sequencer
`ifndef CIRS_CFG_SVH
`define CIRS_CFG_SVH

`define CIRS_NUM_IRQ 42
`define CIRS_IDX_W 6
`define CIRS_PRIMARY_W 32
`define CIRS_EXT_W 10
`define CIRS_BIT_RESET 0
`define CIRS_BIT_EMU 1
`define CIRS_BIT_TIMER 11
`define CIRS_BIT_EXT_LSB 8
`define CIRS_NUM_EXT 3
`define CIRS_PSLOT_LSB 23
`define CIRS_NUM_PSLOT 19
`define CIRS_MASK_RESET 42'h000_0000_0003
`define CIRS_VEC_SPACING 4
`define CIRS_VEC_CYCLES 4
`define CIRS_BLOCK_CYCLES 5
`define CIRS_EXT_LATENCY 5
`define CIRS_DEFER_CYCLES 2
`define CIRS_SQUASH_COUNT 4

`endif

// ===== rtl/cirs_pkg.sv
// Types shared by the interrupt sequencer
package cirs_pkg;
	typedef enum logic [1:0] {CIRS_RUN, CIRS_VECTOR, CIRS_FIRST} cirs_state_t;
	typedef logic [41:0] cirs_vec_t;
endpackage : cirs_pkg

// ===== testbench/cirs_periph_src.sv
// Peripheral request source that holds its request until acknowledged
`timescale 1ns/10ps
module cirs_periph_src (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Event and acknowledge
	input wire logic raise,
	input wire logic ack,
	// Request level
	output logic req
);
	// ----------------------------------------
	// Request level
	// ----------------------------------------
	// Ack wins so a handler read never leaves a stale request behind
	always_ff @(posedge sys_clk) begin
		if (!reset_n) req <= 1'b0;
		else if (ack) req <= 1'b0;
		else if (raise) req <= 1'b1;
	end
endmodule : cirs_periph_src

// ===== testbench/cirs_monitor.sv
// Concurrent checks on the interrupt sequencer ports
`timescale 1ns/10ps
module cirs_monitor #(
	parameter logic [23:0] VEC_BASE = 24'h000000
) (
	// Clock, reset and controls
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic global_enable,
	input wire logic delayed_branch,
	input wire logic pm_conflict,
	// Observed outputs
	input wire logic [31:0] primary_latch_reg,
	input wire logic [31:0] primary_mask_reg,
	input wire logic vector_fetch,
	input wire logic [23:0] vector_addr,
	input wire logic pc_push,
	input wire logic status_push,
	input wire logic squash,
	input wire logic [41:0] in_service
);
	// Index recovered from the vector address
	logic [23:0] vec_idx;
	assign vec_idx = (vector_addr - VEC_BASE) >> 2;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence s_take; vector_fetch && pc_push; endsequence
	sequence s_flush; squash [*4]; endsequence
	property p_redirect; s_take |-> s_flush; endproperty
	a_redirect: assert property (p_redirect) else $error("squash not held");
	property p_push; pc_push == vector_fetch; endproperty
	a_push: assert property (p_push) else $error("push not with vector");
	property p_space; vector_fetch |=> !vector_fetch [*3]; endproperty
	a_space: assert property (p_space) else $error("takes too close");
	property p_clear; (in_service[31:0] & primary_latch_reg) == 32'h0; endproperty
	a_clear: assert property (p_clear) else $error("in-service bit latched");
	property p_vec; vector_fetch |-> in_service[vec_idx]; endproperty
	a_vec: assert property (p_vec) else $error("vector and service differ");
	property p_status; status_push == (vector_fetch && vec_idx inside {[8:11]}); endproperty
	a_status: assert property (p_status) else $error("status push wrong");
	property p_mask; primary_mask_reg[1:0] == 2'h3; endproperty
	a_mask: assert property (p_mask) else $error("reset or emulator masked");
	property p_enable; !$past(global_enable) |-> !vector_fetch; endproperty
	a_enable: assert property (p_enable) else $error("take while disabled");
	property p_defer; (delayed_branch || pm_conflict) |=> !vector_fetch [*3]; endproperty
	a_defer: assert property (p_defer) else $error("take during deferral");
endmodule : cirs_monitor
bind cirs_sequencer cirs_monitor #(.VEC_BASE(VEC_BASE)) u_mon (.sys_clk(sys_clk),
	.reset_n(reset_n), .global_enable(global_enable), .delayed_branch(delayed_branch),
	.pm_conflict(pm_conflict), .primary_latch_reg(primary_latch_reg),
	.primary_mask_reg(primary_mask_reg), .vector_fetch(vector_fetch),
	.vector_addr(vector_addr), .pc_push(pc_push), .status_push(status_push),
	.squash(squash), .in_service(in_service));

// ===== testbench/testbench.sv
// Self-checking bench for the interrupt sequencer
`timescale 1ns/10ps
module testbench;
	logic sys_clk, reset_n, global_enable, nest_enable, core_running, raise, ack, src_req;
	logic [41:0] core_req, in_service;
	logic [2:0] external_request_inputs;
	logic primary_latch_we, primary_mask_we, extended_we, delayed_branch, pm_conflict;
	logic rti_exec, jump_clear_interrupt, vector_fetch, pc_push, status_push, squash;
	logic [31:0] primary_latch_wdata, primary_mask_wdata, primary_latch_reg, primary_mask_reg;
	logic [19:0] extended_wdata, extended_latch_mask_reg;
	logic [23:0] return_addr, vector_addr, pc_push_data;
	int error_cnt = 0;
	int checks = 0;
	cirs_sequencer dut (.sys_clk(sys_clk), .reset_n(reset_n), .core_req(core_req),
		.external_request_inputs(external_request_inputs), .periph_slot_req({18'h0, src_req}),
		.global_enable(global_enable), .nest_enable(nest_enable), .core_running(core_running),
		.primary_latch_we(primary_latch_we), .primary_latch_wdata(primary_latch_wdata),
		.primary_mask_we(primary_mask_we), .primary_mask_wdata(primary_mask_wdata),
		.extended_we(extended_we), .extended_wdata(extended_wdata),
		.delayed_branch(delayed_branch), .pm_conflict(pm_conflict), .rti_exec(rti_exec),
		.jump_clear_interrupt(jump_clear_interrupt), .return_addr(return_addr),
		.primary_latch_reg(primary_latch_reg), .primary_mask_reg(primary_mask_reg),
		.extended_latch_mask_reg(extended_latch_mask_reg), .vector_fetch(vector_fetch),
		.vector_addr(vector_addr), .pc_push(pc_push), .pc_push_data(pc_push_data),
		.status_push(status_push), .squash(squash), .in_service(in_service));
	cirs_periph_src u_src (.sys_clk(sys_clk), .reset_n(reset_n), .raise(raise), .ack(ack),
		.req(src_req));
	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// Whole sequence needs well under a thousand cycles
	initial begin
		#20000;
		error_cnt++;
		final_report();
	end
	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic step();
		@(posedge sys_clk);
		#1;
	endtask : step
	task automatic chk(input string what, input logic [41:0] got, input logic [41:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// One-cycle write strobe; sel 0 latch, 1 mask, 2 extended
	task automatic wr(input int sel, input logic [31:0] d);
		primary_latch_we = (sel == 0);
		primary_mask_we = (sel == 1);
		extended_we = (sel == 2);
		primary_latch_wdata = d;
		primary_mask_wdata = d;
		extended_wdata = d[19:0];
		step();
		{primary_latch_we, primary_mask_we, extended_we} = 3'h0;
	endtask : wr
	// Deferral strobes last one cycle; n of zero skips the latency figure
	task automatic take(input int idx, input int n, input logic [23:0] pd);
		int cnt;
		cnt = 0;
		do begin
			step();
			delayed_branch = 1'b0;
			pm_conflict = 1'b0;
			cnt++;
		end while (vector_fetch !== 1'b1 && cnt < 20);
		if (n != 0) chk("latency", 42'(cnt), 42'(n));
		chk("vector_addr", 42'(vector_addr), 42'(idx * 4));
		chk("push_data", 42'(pc_push_data), 42'(pd));
	endtask : take
	task automatic rti();
		rti_exec = 1'b1;
		step();
		rti_exec = 1'b0;
	endtask : rti
	// Sources drop first; a request still in sync or the delay line would relatch after return
	task automatic retire();
		core_req = 42'h0;
		external_request_inputs = 3'h0;
		repeat (8) step();
		rti();
	endtask : retire
	task automatic final_report();
		$display("error_cnt %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : final_report
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		{reset_n, global_enable, nest_enable, core_running, raise, ack} = 6'h0;
		{primary_latch_we, primary_mask_we, extended_we, delayed_branch, pm_conflict} = 5'h0;
		{rti_exec, jump_clear_interrupt} = 2'h0;
		core_req = 42'h0;
		external_request_inputs = 3'h0;
		{primary_latch_wdata, primary_mask_wdata, extended_wdata} = 84'h0;
		return_addr = 24'h000123;
		repeat (16) @(posedge sys_clk);
		#1 reset_n = 1'b1;
		chk("mask_reset", 42'(primary_mask_reg), 42'h3);
		chk("latch_reset", 42'(primary_latch_reg), 42'h0);
		wr(1, 32'hffff_ffff);
		wr(2, 32'h000f_fc00);
		chk("ext_view", 42'(extended_latch_mask_reg), 42'hffc00);
		wr(0, 32'h0010_0003);
		chk("latch_set", 42'(primary_latch_reg), 42'h100000);
		wr(0, 32'h0);
		chk("latch_clr", 42'(primary_latch_reg), 42'h0);
		{global_enable, core_running} = 2'h3;
		// Held request: retaken only after jump-clear or return
		core_req = 42'h20;
		take(5, 3, 24'h000123);
		repeat (3) step();
		chk("held_latch", 42'(primary_latch_reg[5]), 42'h0);
		jump_clear_interrupt = 1'b1;
		step();
		jump_clear_interrupt = 1'b0;
		take(5, 0, 24'h000123);
		rti();
		take(5, 0, 24'h000123);
		retire();
		// Simultaneous requests resolve to the lower index
		core_req = 42'h88;
		take(3, 3, 24'h000123);
		core_req = 42'h80;
		repeat (2) step();
		rti();
		take(7, 0, 24'h000123);
		retire();
		// Masked request stays pending until unmasked
		wr(1, 32'hffff_ffbf);
		core_req = 42'h40;
		repeat (4) step();
		chk("masked_latch", 42'(primary_latch_reg[6]), 42'h1);
		chk("masked_idle", in_service, 42'h0);
		wr(1, 32'hffff_ffff);
		take(6, 0, 24'h000123);
		retire();
		// Global disable holds a latched request back until enabled again
		global_enable = 1'b0;
		core_req = 42'h4;
		repeat (4) step();
		chk("gated_idle", in_service, 42'h0);
		global_enable = 1'b1;
		take(2, 0, 24'h000123);
		retire();
		// With nesting, a higher request waits out vector fetch and first handler cycle
		nest_enable = 1'b1;
		core_req = 42'h80;
		take(7, 3, 24'h000123);
		core_req = 42'h88;
		take(3, 6, 24'h000123);
		chk("nested_service", in_service, 42'h88);
		retire();
		rti();
		nest_enable = 1'b0;
		// Delayed branch alongside the request pushes the take one cycle later
		core_req = 42'h10;
		delayed_branch = 1'b1;
		take(4, 4, 24'h000123);
		retire();
		// Routed slot request with a memory conflict pushes the next address
		raise = 1'b1;
		step();
		raise = 1'b0;
		pm_conflict = 1'b1;
		take(23, 4, 24'h000124);
		ack = 1'b1;
		step();
		ack = 1'b0;
		retire();
		// External request input carries extra latency
		external_request_inputs = 3'h2;
		take(9, 8, 24'h000123);
		retire();
		repeat (4) step();
		chk("idle_service", in_service, 42'h0);
		chk("idle_latch", 42'(primary_latch_reg), 42'h0);
		final_report();
	end
endmodule : testbench
